// ===== intc_pkg.sv
// Functional notes
// R1 - six request sources, two priority levels
// R2 - one enable register, one priority register
// R3 - priority bit 0 low level, 1 high
// R4 - serve request unless same/higher level active
// R5 - hold request until equal/higher routine ends
// R6 - high level request preempts low routine
// R7 - track both levels, resume suspended routine
// R8 - external flag cleared only when edge mode
// R9 - transmit flag: bit eight end or stop start
// R10 - receive flag: bit eight end or mid stop
// R11 - serial flags sit in serial control register
// R12 - fixed polling order and fixed vectors
// R13 - serial and timer 2 flags software cleared
`default_nettype none
package intc_pkg;
   localparam int unsigned NUM_SRC = 6;
   // register byte addresses
   localparam logic [7:0] OFS_ENABLE = 8'h00;
   localparam logic [7:0] OFS_PRIORITY = 8'h04;
   localparam logic [7:0] OFS_SERIAL = 8'h08;
   localparam logic [7:0] OFS_FLAGS = 8'h0C;
   localparam logic [7:0] OFS_EXT_MODE = 8'h10;
   localparam logic [7:0] OFS_STATE = 8'h14;
   localparam logic [7:0] OFS_EVT_STATUS = 8'h18;
   localparam logic [7:0] OFS_EVT_CLEAR = 8'h1C;
   localparam logic [7:0] OFS_EVT_ENABLE = 8'h20;
   // reset values
   localparam logic [7:0] RST_ENABLE = 8'h00;
   localparam logic [5:0] RST_PRIORITY = 6'h00;
   localparam logic [7:0] RST_SERIAL = 8'h00;
   localparam logic [5:0] RST_FLAGS = 6'h00;
   localparam logic [1:0] RST_EXT_MODE = 2'h0;
   localparam logic [5:0] RST_EVT = 6'h00;
   // enable register fields
   localparam int unsigned EN_GLOBAL = 7;
   // source indices, in polling order
   localparam logic [2:0] SRC_EXT0 = 3'h0;
   localparam logic [2:0] SRC_T0 = 3'h1;
   localparam logic [2:0] SRC_EXT1 = 3'h2;
   localparam logic [2:0] SRC_T1 = 3'h3;
   localparam logic [2:0] SRC_SP = 3'h4;
   localparam logic [2:0] SRC_T2 = 3'h5;
   // serial control fields
   localparam int unsigned SC_RX_DONE = 0;
   localparam int unsigned SC_TX_DONE = 1;
   localparam int unsigned SC_RX_NINTH = 2;
   localparam int unsigned SC_TX_NINTH = 3;
   localparam int unsigned SC_REN = 4;
   localparam int unsigned SC_SM2 = 5;
   localparam int unsigned SC_MODE_LO = 6;
   localparam int unsigned SC_MODE_HI = 7;
   // request flag fields
   localparam int unsigned FL_EXT0 = 0;
   localparam int unsigned FL_T0 = 1;
   localparam int unsigned FL_EXT1 = 2;
   localparam int unsigned FL_T1 = 3;
   localparam int unsigned FL_T2_OVF = 4;
   localparam int unsigned FL_T2_EXT = 5;
   // external mode fields, 1 = transition activated
   localparam int unsigned MD_EXT0_EDGE = 0;
   localparam int unsigned MD_EXT1_EDGE = 1;
   // vectors
   localparam logic [7:0] VEC_BASE = 8'h03;
   localparam logic [7:0] VEC_STEP = 8'h08;
   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      HS_IDLE = 2'b01,
      HS_OFFER = 2'b10
   } hs_e;

   function automatic logic [7:0] vector_of(input logic [2:0] idx);
      vector_of = 8'(VEC_BASE + 8'(idx) * VEC_STEP);
   endfunction : vector_of
endpackage : intc_pkg
`default_nettype wire

// ===== int_pin_sync.sv
`default_nettype none
module int_pin_sync (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // pin, active low
   input wire logic pin_n_i,
   // synchronised outputs
   output logic low_o,
   output logic fall_o
);
   typedef struct packed {
      logic meta;
      logic sync;
      logic prev;
   } sync_s;

   sync_s s_reg;
   sync_s s_next;

   always_comb begin
      s_next.meta = pin_n_i;
      s_next.sync = s_reg.meta;
      s_next.prev = s_reg.sync;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_reg <= '1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign low_o = ~s_reg.sync;
   assign fall_o = s_reg.prev & ~s_reg.sync;
endmodule : int_pin_sync
`default_nettype wire

// ===== int_poll_arbiter.sv
`default_nettype none
module int_poll_arbiter #(
   parameter int unsigned N = 6
) (
   // requests and their levels
   input wire logic [N-1:0] req_i,
   input wire logic [N-1:0] level_i,
   // winner
   output logic valid_o,
   output logic [2:0] idx_o,
   output logic level_o
);
   logic [N-1:0] hi;
   logic [N-1:0] lo;

   // lowest index wins within a level
   function automatic logic [2:0] first_set(input logic [N-1:0] v);
      first_set = 3'h0;
      for (int i = N - 1; i >= 0; i--) begin
         if (v[i]) begin
            first_set = 3'(i);
         end
      end
   endfunction : first_set

   always_comb begin
      hi = req_i & level_i; // [R3]
      lo = req_i & ~level_i;
      valid_o = |req_i;
      level_o = |hi;
      if (|hi) begin // [R12]
         idx_o = first_set(hi);
      end else begin
         idx_o = first_set(lo);
      end
   end
endmodule : int_poll_arbiter
`default_nettype wire

// ===== intc_top.sv
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`default_nettype none
module intc_top (
   // clock and reset
   input wire logic CLK_I,
   input wire logic RST_I,
   // axi4-lite write
   input wire logic [7:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   // axi4-lite read
   input wire logic [7:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   // external request pins
   input wire logic EXT0_N_I,
   input wire logic EXT1_N_I,
   // timer and serial events, one-cycle pulses
   input wire logic TIMER0_OVF_I,
   input wire logic TIMER1_OVF_I,
   input wire logic TIMER2_OVF_I,
   input wire logic TIMER2_EXT_I,
   input wire logic TX_DATA8_END_I,
   input wire logic TX_STOP_START_I,
   input wire logic RX_DATA8_END_I,
   input wire logic RX_STOP_HALF_I,
   input wire logic RX_NINTH_I,
   // core vectoring
   output logic INT_REQ_O,
   output logic [7:0] INT_VECTOR_O,
   output logic INT_LEVEL_O,
   input wire logic INT_ACK_I,
   input wire logic INT_RETURN_I,
   // serial port controls
   output logic [1:0] SERIAL_MODE_O,
   output logic SERIAL_SM2_O,
   output logic SERIAL_REN_O,
   output logic TX_NINTH_O,
   // event interrupt
   output logic IRQ_O
);
   localparam int unsigned N = intc_pkg::NUM_SRC;

   typedef struct packed {
      logic awready;
      logic aw_full;
      logic [7:0] awaddr;
      logic wready;
      logic w_full;
      logic [31:0] wdata;
      logic wstrb0;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [7:0] interrupt_enable_reg;
      logic [5:0] priority_select_reg;
      logic [7:0] serial_control_reg;
      logic [5:0] flags;
      logic [1:0] ext_mode;
      logic [5:0] evt_status;
      logic [5:0] evt_enable;
      logic [1:0] in_service;
      intc_pkg::hs_e hs;
      logic req;
      logic [7:0] vector;
      logic level;
      logic [2:0] src;
      logic irq;
   } state_s;

   state_s s_reg;
   state_s s_next;

   logic ext0_low;
   logic ext0_fall;
   logic ext1_low;
   logic ext1_fall;
   logic [N-1:0] pend;
   logic win_valid;
   logic [2:0] win_idx;
   logic win_level;

   int_pin_sync u_ext0 (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .pin_n_i(EXT0_N_I),
      .low_o(ext0_low),
      .fall_o(ext0_fall)
   );

   int_pin_sync u_ext1 (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .pin_n_i(EXT1_N_I),
      .low_o(ext1_low),
      .fall_o(ext1_fall)
   );

   // pending sources in polling order
   always_comb begin
      pend[intc_pkg::SRC_EXT0] = s_reg.flags[intc_pkg::FL_EXT0]; // [R1]
      pend[intc_pkg::SRC_T0] = s_reg.flags[intc_pkg::FL_T0];
      pend[intc_pkg::SRC_EXT1] = s_reg.flags[intc_pkg::FL_EXT1];
      pend[intc_pkg::SRC_T1] = s_reg.flags[intc_pkg::FL_T1];
      pend[intc_pkg::SRC_SP] = s_reg.serial_control_reg[intc_pkg::SC_TX_DONE]
         | s_reg.serial_control_reg[intc_pkg::SC_RX_DONE];
      pend[intc_pkg::SRC_T2] = s_reg.flags[intc_pkg::FL_T2_OVF]
         | s_reg.flags[intc_pkg::FL_T2_EXT];
      pend = pend & s_reg.interrupt_enable_reg[N-1:0]
         & {N{s_reg.interrupt_enable_reg[intc_pkg::EN_GLOBAL]}}; // [R2]
   end

   int_poll_arbiter #(
      .N(N)
   ) u_arb (
      .req_i(pend),
      .level_i(s_reg.priority_select_reg),
      .valid_o(win_valid),
      .idx_o(win_idx),
      .level_o(win_level)
   );

   function automatic logic [31:0] read_word(input logic [7:0] a, input state_s st);
      case (a)
         intc_pkg::OFS_ENABLE: read_word = {24'h0, st.interrupt_enable_reg};
         intc_pkg::OFS_PRIORITY: read_word = {26'h0, st.priority_select_reg};
         intc_pkg::OFS_SERIAL: read_word = {24'h0, st.serial_control_reg};
         intc_pkg::OFS_FLAGS: read_word = {26'h0, st.flags};
         intc_pkg::OFS_EXT_MODE: read_word = {30'h0, st.ext_mode};
         intc_pkg::OFS_STATE: read_word = {16'h0, st.vector, 1'b0, st.src,
            st.level, st.req, st.in_service};
         intc_pkg::OFS_EVT_STATUS: read_word = {26'h0, st.evt_status};
         intc_pkg::OFS_EVT_ENABLE: read_word = {26'h0, st.evt_enable};
         default: read_word = 32'h0000_0000;
      endcase
   endfunction : read_word

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a <= intc_pkg::OFS_EVT_ENABLE) && (a[1:0] == 2'h0);
   endfunction : mapped

   always_comb begin
      logic wr;
      logic [7:0] wd;
      logic [5:0] evt_clr;
      logic [5:0] set_src;
      logic allowed;
      logic sc_mode0;
      logic tx_set;
      logic rx_set;
      wr = 1'b0;
      wd = 8'h00;
      evt_clr = 6'h00;
      set_src = 6'h00;
      allowed = 1'b0;
      s_next = s_reg;

      // bus write channels
      if (S_AXI_AWVALID_I && s_reg.awready) begin
         s_next.aw_full = 1'b1;
         s_next.awready = 1'b0;
         s_next.awaddr = S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && s_reg.wready) begin
         s_next.w_full = 1'b1;
         s_next.wready = 1'b0;
         s_next.wdata = S_AXI_WDATA_I;
         s_next.wstrb0 = S_AXI_WSTRB_I[0];
      end
      if (s_reg.bvalid && S_AXI_BREADY_I) s_next.bvalid = 1'b0;
      if (s_reg.aw_full && s_reg.w_full && !s_reg.bvalid) begin
         wr = s_reg.wstrb0;
         wd = s_reg.wdata[7:0];
         s_next.aw_full = 1'b0;
         s_next.w_full = 1'b0;
         s_next.awready = 1'b1;
         s_next.wready = 1'b1;
         s_next.bvalid = 1'b1;
         s_next.bresp = mapped(s_reg.awaddr) ? intc_pkg::RESP_OKAY : intc_pkg::RESP_SLVERR;
      end

      // bus read channels
      if (s_reg.rvalid && S_AXI_RREADY_I) begin
         s_next.rvalid = 1'b0;
         s_next.arready = 1'b1;
      end
      if (S_AXI_ARVALID_I && s_reg.arready) begin
         s_next.arready = 1'b0;
         s_next.rvalid = 1'b1;
         s_next.rdata = read_word(S_AXI_ARADDR_I, s_reg);
         s_next.rresp = mapped(S_AXI_ARADDR_I) ? intc_pkg::RESP_OKAY : intc_pkg::RESP_SLVERR;
      end

      // software register writes
      if (wr) begin
         case (s_reg.awaddr)
            intc_pkg::OFS_ENABLE: s_next.interrupt_enable_reg = {wd[7], 1'b0, wd[5:0]}; // [R2]
            intc_pkg::OFS_PRIORITY: s_next.priority_select_reg = wd[5:0]; // [R2]
            intc_pkg::OFS_SERIAL: s_next.serial_control_reg = wd; // [R11]
            intc_pkg::OFS_FLAGS: s_next.flags = wd[5:0]; // [R13]
            intc_pkg::OFS_EXT_MODE: s_next.ext_mode = wd[1:0];
            intc_pkg::OFS_EVT_CLEAR: evt_clr = wd[5:0];
            intc_pkg::OFS_EVT_ENABLE: s_next.evt_enable = wd[5:0];
            default: ;
         endcase
      end

      // routine finished: innermost level leaves service
      if (INT_RETURN_I) begin
         if (s_reg.in_service[1]) s_next.in_service[1] = 1'b0; // [R7]
         else s_next.in_service[0] = 1'b0;
      end

      // vector taken by the core
      if (s_reg.hs == intc_pkg::HS_OFFER && INT_ACK_I) begin
         s_next.in_service[s_reg.level] = 1'b1; // [R6] [R7]
         s_next.req = 1'b0;
         s_next.hs = intc_pkg::HS_IDLE;
         case (s_reg.src)
            intc_pkg::SRC_EXT0: if (s_reg.ext_mode[intc_pkg::MD_EXT0_EDGE])
               s_next.flags[intc_pkg::FL_EXT0] = 1'b0; // [R8]
            intc_pkg::SRC_EXT1: if (s_reg.ext_mode[intc_pkg::MD_EXT1_EDGE])
               s_next.flags[intc_pkg::FL_EXT1] = 1'b0; // [R8]
            intc_pkg::SRC_T0: s_next.flags[intc_pkg::FL_T0] = 1'b0;
            intc_pkg::SRC_T1: s_next.flags[intc_pkg::FL_T1] = 1'b0;
            default: ; // serial and timer 2 keep their flags [R13]
         endcase
      end else begin
         // offer the winner only if no equal or higher level is in service
         if (win_level) begin
            allowed = win_valid && !s_reg.in_service[1]; // [R4] [R6]
         end else begin
            allowed = win_valid && (s_reg.in_service == 2'b00); // [R4] [R5]
         end
         if (allowed) begin
            s_next.hs = intc_pkg::HS_OFFER;
            s_next.req = 1'b1;
            s_next.src = win_idx;
            s_next.level = win_level;
            s_next.vector = intc_pkg::vector_of(win_idx); // [R12]
         end else begin
            s_next.hs = intc_pkg::HS_IDLE; // [R5]
            s_next.req = 1'b0;
         end
      end

      // hardware flag setting, wins over any clear
      sc_mode0 = (s_reg.serial_control_reg[intc_pkg::SC_MODE_HI:intc_pkg::SC_MODE_LO] == 2'b00);
      tx_set = sc_mode0 ? TX_DATA8_END_I : TX_STOP_START_I; // [R9]
      rx_set = sc_mode0 ? RX_DATA8_END_I : RX_STOP_HALF_I; // [R10]
      if (tx_set) s_next.serial_control_reg[intc_pkg::SC_TX_DONE] = 1'b1; // [R11]
      if (rx_set) begin
         s_next.serial_control_reg[intc_pkg::SC_RX_DONE] = 1'b1; // [R11]
         s_next.serial_control_reg[intc_pkg::SC_RX_NINTH] = RX_NINTH_I;
      end
      if (TIMER0_OVF_I) s_next.flags[intc_pkg::FL_T0] = 1'b1;
      if (TIMER1_OVF_I) s_next.flags[intc_pkg::FL_T1] = 1'b1;
      if (TIMER2_OVF_I) s_next.flags[intc_pkg::FL_T2_OVF] = 1'b1;
      if (TIMER2_EXT_I) s_next.flags[intc_pkg::FL_T2_EXT] = 1'b1;
      if (s_reg.ext_mode[intc_pkg::MD_EXT0_EDGE]) begin
         if (ext0_fall) s_next.flags[intc_pkg::FL_EXT0] = 1'b1; // [R8]
      end else begin
         s_next.flags[intc_pkg::FL_EXT0] = ext0_low; // [R8]
      end
      if (s_reg.ext_mode[intc_pkg::MD_EXT1_EDGE]) begin
         if (ext1_fall) s_next.flags[intc_pkg::FL_EXT1] = 1'b1; // [R8]
      end else begin
         s_next.flags[intc_pkg::FL_EXT1] = ext1_low; // [R8]
      end

      // sticky events: a timer or serial set pulse, or an external flag rising
      set_src[intc_pkg::SRC_EXT0] = s_next.flags[intc_pkg::FL_EXT0]
         & ~s_reg.flags[intc_pkg::FL_EXT0];
      set_src[intc_pkg::SRC_T0] = TIMER0_OVF_I;
      set_src[intc_pkg::SRC_EXT1] = s_next.flags[intc_pkg::FL_EXT1]
         & ~s_reg.flags[intc_pkg::FL_EXT1];
      set_src[intc_pkg::SRC_T1] = TIMER1_OVF_I;
      set_src[intc_pkg::SRC_SP] = tx_set | rx_set;
      set_src[intc_pkg::SRC_T2] = TIMER2_OVF_I | TIMER2_EXT_I;
      s_next.evt_status = (s_reg.evt_status & ~evt_clr) | set_src;
      s_next.irq = |(s_next.evt_status & s_next.evt_enable);
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         s_reg <= '0;
         s_reg.awready <= 1'b1;
         s_reg.wready <= 1'b1;
         s_reg.arready <= 1'b1;
         s_reg.interrupt_enable_reg <= intc_pkg::RST_ENABLE;
         s_reg.priority_select_reg <= intc_pkg::RST_PRIORITY;
         s_reg.serial_control_reg <= intc_pkg::RST_SERIAL;
         s_reg.flags <= intc_pkg::RST_FLAGS;
         s_reg.ext_mode <= intc_pkg::RST_EXT_MODE;
         s_reg.evt_status <= intc_pkg::RST_EVT;
         s_reg.evt_enable <= intc_pkg::RST_EVT;
         s_reg.hs <= intc_pkg::HS_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign S_AXI_AWREADY_O = s_reg.awready;
   assign S_AXI_WREADY_O = s_reg.wready;
   assign S_AXI_BRESP_O = s_reg.bresp;
   assign S_AXI_BVALID_O = s_reg.bvalid;
   assign S_AXI_ARREADY_O = s_reg.arready;
   assign S_AXI_RDATA_O = s_reg.rdata;
   assign S_AXI_RRESP_O = s_reg.rresp;
   assign S_AXI_RVALID_O = s_reg.rvalid;
   assign INT_REQ_O = s_reg.req;
   assign INT_VECTOR_O = s_reg.vector;
   assign INT_LEVEL_O = s_reg.level;
   assign SERIAL_MODE_O = s_reg.serial_control_reg[intc_pkg::SC_MODE_HI:intc_pkg::SC_MODE_LO];
   assign SERIAL_SM2_O = s_reg.serial_control_reg[intc_pkg::SC_SM2];
   assign SERIAL_REN_O = s_reg.serial_control_reg[intc_pkg::SC_REN];
   assign TX_NINTH_O = s_reg.serial_control_reg[intc_pkg::SC_TX_NINTH];
   assign IRQ_O = s_reg.irq;
endmodule : intc_top
`default_nettype wire

// ===== intc_top_asserts.sv
`default_nettype none
module intc_top_asserts (
   // clock and reset
   input wire logic CLK_I,
   input wire logic RST_I,
   // register bus
   input wire logic S_AXI_AWVALID_I,
   input wire logic S_AXI_AWREADY_O,
   input wire logic S_AXI_WVALID_I,
   input wire logic S_AXI_WREADY_O,
   input wire logic [1:0] S_AXI_BRESP_O,
   input wire logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic S_AXI_ARVALID_I,
   input wire logic S_AXI_ARREADY_O,
   input wire logic [31:0] S_AXI_RDATA_O,
   input wire logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   // core vectoring
   input wire logic INT_REQ_O,
   input wire logic [7:0] INT_VECTOR_O,
   input wire logic INT_LEVEL_O,
   input wire logic INT_ACK_I,
   input wire logic INT_RETURN_I
);
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (RST_I);
   logic [1:0] svc_reg;
   logic [1:0] svc_next;
   always_comb begin
      svc_next = svc_reg;
      if (INT_RETURN_I) begin
         if (svc_reg[1]) svc_next[1] = 1'h0;
         else svc_next[0] = 1'h0;
      end
      if (INT_ACK_I && INT_REQ_O) svc_next[INT_LEVEL_O] = 1'h1;
   end
   always_ff @(posedge CLK_I) begin
      if (RST_I) svc_reg <= 2'h0;
      else svc_reg <= svc_next;
   end
   property p_hi_block;
      INT_REQ_O |-> !svc_reg[1];
   endproperty
   a_hi_block: assert property (p_hi_block) else $error("offer during high routine");
   property p_lo_block;
      INT_REQ_O && !INT_LEVEL_O |-> svc_reg == 2'h0;
   endproperty
   a_lo_block: assert property (p_lo_block) else $error("low offer while busy");
   property p_ack_drop;
      INT_REQ_O && INT_ACK_I |=> !INT_REQ_O;
   endproperty
   a_ack_drop: assert property (p_ack_drop) else $error("offer kept after ack");
   property p_vec_table;
      INT_REQ_O |-> INT_VECTOR_O[2:0] == 3'h3 && INT_VECTOR_O <= 8'h2B;
   endproperty
   a_vec_table: assert property (p_vec_table) else $error("vector off table");
   property p_b_hold;
      S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_r_hold;
      S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   property p_r_lat;
      S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O;
   endproperty
   a_r_lat: assert property (p_r_lat) else $error("read answer late");
   property p_w_lat;
      S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O
         |-> ##[1:2] S_AXI_BVALID_O;
   endproperty
   a_w_lat: assert property (p_w_lat) else $error("write answer late");
   c_lo_take: cover property (INT_ACK_I && INT_REQ_O && !INT_LEVEL_O);
   c_preempt: cover property (INT_ACK_I && INT_REQ_O && INT_LEVEL_O && svc_reg == 2'h1);
   c_slverr: cover property (S_AXI_BVALID_O && S_AXI_BRESP_O == intc_pkg::RESP_SLVERR);
endmodule : intc_top_asserts
bind intc_top intc_top_asserts u_chk (.*);
`default_nettype wire

// ===== core_model.sv
`default_nettype none
module core_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // offered vector
   input wire logic int_req_i,
   input wire logic [7:0] int_vector_i,
   input wire logic int_level_i,
   // bench controls
   input wire logic stall_i,
   input wire logic ret_cmd_i,
   // answers to the controller
   output logic ack_o,
   output logic ret_o,
   // taken count and last taken vector
   output logic [7:0] cnt_o,
   output logic [7:0] vec_o,
   output logic lvl_o
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'h0;
         ret_o <= 1'h0;
         cnt_o <= 8'h00;
         vec_o <= 8'h00;
         lvl_o <= 1'h0;
      end else begin
         ack_o <= int_req_i && !ack_o && !stall_i;
         ret_o <= ret_cmd_i;
         if (ack_o && int_req_i) begin
            cnt_o <= cnt_o + 8'h01;
            vec_o <= int_vector_i;
            lvl_o <= int_level_i;
         end
      end
   end
endmodule : core_model
`default_nettype wire

// ===== test_two_level_interrupt_nesting.sv
`default_nettype none
module test_two_level_interrupt_nesting;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [10:0] m; logic [7:0] vec; logic [7:0] a; logic [7:0] e;} row_s;
   localparam logic [7:0] A_FL = intc_pkg::OFS_FLAGS;
   localparam logic [7:0] A_SC = intc_pkg::OFS_SERIAL;
   localparam logic [1:0] OK = intc_pkg::RESP_OKAY;
   row_s rows [0:5] = '{'{11'h001, 8'h03, A_FL, 8'h00}, '{11'h002, 8'h0B, A_FL, 8'h00},
      '{11'h004, 8'h13, A_FL, 8'h00}, '{11'h008, 8'h1B, A_FL, 8'h00},
      '{11'h110, 8'h23, A_SC, 8'h03}, '{11'h020, 8'h2B, A_FL, 8'h10}};
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'h0;
   logic wvalid = 1'h0;
   logic bready = 1'h0;
   logic arvalid = 1'h0;
   logic rready = 1'h0;
   logic [10:0] ev = 11'h000;
   logic stall = 1'h0;
   logic ret_cmd = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, int_req, int_level, ack, ret, irq, tk_lvl;
   logic sm2, ren, tb8;
   logic [1:0] bresp, rresp, smode;
   logic [31:0] rdata, d;
   logic [7:0] int_vec, cnt, tk_vec;
   int n_mismatch = 0;
   int checked = 0;
   int ntk = 0;
   always #50 clk = ~clk;
   intc_top dut (.CLK_I(clk), .RST_I(rst), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
      .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF),
      .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
      .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
      .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
      .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
      .EXT0_N_I(~ev[0]), .EXT1_N_I(~ev[2]), .TIMER0_OVF_I(ev[1]), .TIMER1_OVF_I(ev[3]),
      .TIMER2_OVF_I(ev[5]), .TIMER2_EXT_I(ev[6]), .TX_DATA8_END_I(ev[4]),
      .TX_STOP_START_I(ev[7]), .RX_DATA8_END_I(ev[8]), .RX_STOP_HALF_I(ev[9]),
      .RX_NINTH_I(ev[10]), .INT_REQ_O(int_req), .INT_VECTOR_O(int_vec),
      .INT_LEVEL_O(int_level), .INT_ACK_I(ack), .INT_RETURN_I(ret), .SERIAL_MODE_O(smode),
      .SERIAL_SM2_O(sm2), .SERIAL_REN_O(ren), .TX_NINTH_O(tb8), .IRQ_O(irq));
   core_model u_core (.clk_i(clk), .rst_i(rst), .int_req_i(int_req), .int_vector_i(int_vec),
      .int_level_i(int_level), .stall_i(stall), .ret_cmd_i(ret_cmd), .ack_o(ack), .ret_o(ret),
      .cnt_o(cnt), .vec_o(tk_vec), .lvl_o(tk_lvl));
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         $display("BAD %s exp %h got %h", nm, e, s);
         n_mismatch++;
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h0, v};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (bvalid !== 1'h1);
      chk("bresp", 32'(er), 32'(bresp));
      bready <= 1'h0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'h0;
      end while (rvalid !== 1'h1);
      v = rdata;
      chk("rresp", 32'(er), 32'(rresp));
      rready <= 1'h0;
   endtask : rd
   task rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] v;
      rd(a, OK, v);
      chk(nm, e, v & m);
   endtask : rdc
   task pulse(input logic [10:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 11'h000;
   endtask : pulse
   task take(input logic [7:0] ev_vec, input logic el);
      int n;
      n = 0;
      while (cnt !== 8'(ntk + 1) && n < 40) begin
         @(posedge clk);
         n++;
      end
      chk("taken", 32'(ntk + 1), 32'(cnt));
      ntk++;
      chk("vector", 32'(ev_vec), 32'(tk_vec));
      chk("level", 32'(el), 32'(tk_lvl));
   endtask : take
   task none(input string nm);
      repeat (12) @(posedge clk);
      chk(nm, 32'(ntk), 32'(cnt));
   endtask : none
   task finish_routine();
      @(posedge clk);
      ret_cmd <= 1'h1;
      @(posedge clk);
      ret_cmd <= 1'h0;
      repeat (2) @(posedge clk);
   endtask : finish_routine
   task wrap_up();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      wrap_up();
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      chk("req after reset", 32'h0, 32'(int_req));
      rdc("enable", intc_pkg::OFS_ENABLE, 32'hFF, 32'(intc_pkg::RST_ENABLE));
      rdc("priority", intc_pkg::OFS_PRIORITY, 32'hFF, 32'h0);
      wr(intc_pkg::OFS_ENABLE, 8'hFF, OK);
      rdc("enable", intc_pkg::OFS_ENABLE, 32'hFFFFFFFF, 32'hBF);
      rd(8'hFC, intc_pkg::RESP_SLVERR, d);
      chk("unmapped", 32'h0, d);
      wr(8'hFC, 8'h12, intc_pkg::RESP_SLVERR);
      wr(intc_pkg::OFS_EXT_MODE, 8'h03, OK);
      for (int i = 0; i < 6; i++) begin
         pulse(rows[i].m);
         take(rows[i].vec, 1'h0);
         rdc("flags", rows[i].a, 32'hFF, {24'h0, rows[i].e});
         wr(A_FL, 8'h00, OK);
         wr(A_SC, 8'h00, OK);
         finish_routine();
      end
      wr(intc_pkg::OFS_EXT_MODE, 8'h00, OK);
      ev <= 11'h001;
      take(8'h03, 1'h0);
      rdc("level flag", A_FL, 32'h01, 32'h01);
      ev <= 11'h000;
      repeat (4) @(posedge clk);
      rdc("level flag", A_FL, 32'h01, 32'h00);
      finish_routine();
      stall <= 1'h1;
      pulse(11'h022);
      repeat (3) @(posedge clk);
      stall <= 1'h0;
      take(8'h0B, 1'h0);
      none("same level held");
      finish_routine();
      take(8'h2B, 1'h0);
      wr(A_FL, 8'h00, OK);
      finish_routine();
      wr(intc_pkg::OFS_PRIORITY, 8'h08, OK);
      pulse(11'h002);
      take(8'h0B, 1'h0);
      pulse(11'h008);
      take(8'h1B, 1'h1);
      pulse(11'h002);
      none("low held");
      finish_routine();
      rdc("in service", intc_pkg::OFS_STATE, 32'h3, 32'h1);
      none("still held");
      finish_routine();
      take(8'h0B, 1'h0);
      finish_routine();
      wr(intc_pkg::OFS_ENABLE, 8'h3F, OK);
      wr(intc_pkg::OFS_EVT_CLEAR, 8'h3F, OK);
      pulse(11'h008);
      rdc("status", intc_pkg::OFS_EVT_STATUS, 32'h3F, 32'h08);
      chk("irq masked", 32'h0, 32'(irq));
      wr(intc_pkg::OFS_EVT_ENABLE, 8'h08, OK);
      repeat (2) @(posedge clk);
      chk("irq", 32'h1, 32'(irq));
      wr(intc_pkg::OFS_EVT_CLEAR, 8'h08, OK);
      repeat (2) @(posedge clk);
      chk("irq cleared", 32'h0, 32'(irq));
      wr(A_SC, 8'h78, OK);
      chk("mode", 32'h1, 32'(smode));
      chk("sm2 ren tb8", 32'h7, 32'({sm2, ren, tb8}));
      pulse(11'h110);
      rdc("serial", A_SC, 32'hFF, 32'h78);
      pulse(11'h680);
      rdc("serial", A_SC, 32'hFF, 32'h7F);
      pulse(11'h040);
      rdc("t2 external", A_FL, 32'h20, 32'h20);
      wr(A_SC, 8'h00, OK);
      wr(A_FL, 8'h00, OK);
      wrap_up();
   end
endmodule : test_two_level_interrupt_nesting
`default_nettype wire
